// File: dv/tb_three_wire_serial_port.sv
// Self-checking bench of the three-wire serial port
`timescale 1ns/10ps
`include "tws_params.svh"
module tb_three_wire_serial_port;
	logic mclk, rst_b, reg_wr, reg_rd, reg_bit_wr, reg_bit_val, ss_b, sck, sdi, sdo;
	logic [15:0] reg_addr;
	logic [2:0] reg_bit_idx;
	logic [7:0] reg_wdata, reg_rdata, d, t, p, q, m;
	logic [31:0] seed, s;
	logic [15:0] a [4] = '{`TWS_MODE_ADDR, `TWS_TXB_ADDR, `TWS_SIO_ADDR, 16'hFF81};
	int errors, n_tests;
	// ----
	// Harness
	// ----
	tws_port u_dut (.mclk, .rst_b, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_bit_wr, .reg_bit_idx,
		.reg_bit_val, .reg_rdata, .serial_clock_line(sck), .serial_in_line(sdi), .slave_select_input_b(ss_b),
		.serial_out_line(sdo));
	tws_peer u_peer (.sck, .sdi, .sdo);
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [7:0] ord(input logic [7:0] v, input logic lsb);
		logic [7:0] r;
		for (int i = 0; i < 8; i++) r[i] = lsb ? v[7 - i] : v[i];
		return r;
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		if (errors == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [15:0] ad, input logic [7:0] v);
		@(posedge mclk);
		#1 reg_addr = ad;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(posedge mclk);
		#1 reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [15:0] ad, output logic [7:0] v);
		@(posedge mclk);
		#1 reg_addr = ad;
		reg_rd = 1'b1;
		@(posedge mclk);
		#1 reg_rd = 1'b0;
		v = reg_rdata;
	endtask
	task automatic bw(input logic [2:0] i, input logic v);
		@(posedge mclk);
		#1 reg_addr = `TWS_MODE_ADDR;
		reg_bit_idx = i;
		reg_bit_val = v;
		reg_bit_wr = 1'b1;
		@(posedge mclk);
		#1 reg_bit_wr = 1'b0;
	endtask
	task automatic idle();
		for (int k = 0; k < 40; k++) begin
			rd(`TWS_MODE_ADDR, d);
			if (d[0] === 1'b0) return;
		end
		errors++;
		close_out();
	endtask
	// ----
	// Sequence
	// ----
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	initial begin
		{rst_b, reg_wr, reg_rd, reg_bit_wr, reg_bit_val} = 5'h00;
		ss_b = 1'b1;
		reg_addr = 16'h0000;
		reg_wdata = 8'h00;
		reg_bit_idx = 3'h0;
		errors = 0;
		n_tests = 0;
		seed = 32'h4D04;
		repeat (6) @(posedge mclk);
		#1 rst_b = 1'b1;
		for (int i = 0; i < 4; i++) begin
			rd(a[i], d);
			chk(d, 8'h00);
		end
		t = 8'(rnd());
		wr(`TWS_TXB_ADDR, t);
		rd(`TWS_TXB_ADDR, d);
		chk(d, t);
		wr(`TWS_MODE_ADDR, 8'hFF);
		rd(`TWS_MODE_ADDR, d);
		chk(d, 8'hF0);
		bw(3'h4, 1'b0);
		rd(`TWS_MODE_ADDR, d);
		chk(d, 8'hE0);
		wr(`TWS_TXB_ADDR, t);
		rd(`TWS_MODE_ADDR, d);
		chk(d, 8'hE0);
		wr(`TWS_MODE_ADDR, 8'hA0);
		rd(`TWS_SIO_ADDR, d);
		rd(`TWS_MODE_ADDR, d);
		chk(d, 8'hA0);
		wr(`TWS_MODE_ADDR, 8'h40);
		wr(`TWS_TXB_ADDR, t);
		rd(`TWS_MODE_ADDR, d);
		chk(d, 8'h40);
		for (int n = 0; n < 8; n++) begin
			s = rnd();
			m = {2'h3, s[0], s[1], 4'h0};
			ss_b = s[0] ? 1'b0 : s[3];
			#20 wr(`TWS_MODE_ADDR, m);
			t = (n == 0) ? 8'h01 : 8'(rnd());
			p = 8'(rnd());
			wr(`TWS_TXB_ADDR, t);
			rd(`TWS_MODE_ADDR, d);
			chk(d, m | 8'h01);
			#(s[6:4]) u_peer.frame(p, q);
			idle();
			chk(q, ord(t, m[4]));
			rd(`TWS_SIO_ADDR, d);
			chk(d, ord(p, m[4]));
		end
		wr(`TWS_MODE_ADDR, 8'h90);
		rd(`TWS_SIO_ADDR, d);
		p = 8'(rnd());
		#3 u_peer.frame(p, q);
		chk(q, 8'h00);
		idle();
		rd(`TWS_SIO_ADDR, d);
		chk(d, ord(p, 1'b1));
		rd(`TWS_MODE_ADDR, d);
		chk(d, 8'h91);
		wr(`TWS_MODE_ADDR, 8'h00);
		rd(`TWS_MODE_ADDR, d);
		chk(d, 8'h00);
		rd(`TWS_SIO_ADDR, d);
		chk(d, 8'h00);
		close_out();
	end
endmodule

// File: dv/tws_peer.sv
// Far-side peripheral model driving the serial clock
`timescale 1ns/10ps
module tws_peer (
	// Link
	output logic sck,
	output logic sdi,
	input wire logic sdo
);
	// ----
	// Frame
	// ----
	initial begin
		sck = 1'b0;
		sdi = 1'b0;
	end
	task automatic frame(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sdi = tx[i];
			#62.5 sck = 1'b1;
			rx[i] = sdo;
			#62.5 sck = 1'b0;
		end
		sdi = ~sdi;
	endtask
endmodule

// File: dv/tws_port_properties.sv
// Port-level checks of the three-wire serial port
`timescale 1ns/10ps
`include "tws_params.svh"
module tws_port_props (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Register port
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_bit_wr,
	input wire logic [2:0] reg_bit_idx,
	input wire logic reg_bit_val,
	input wire logic [7:0] reg_rdata,
	// Link
	input wire logic serial_clock_line,
	input wire logic serial_out_line
);
	// ----
	// Checks
	// ----
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	AST_RD_STAND: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved");
	AST_RSV_ZERO: assert property (reg_rd && reg_addr == `TWS_MODE_ADDR |=> reg_rdata[3:1] == 3'h0)
		else $error("reserved bits set");
	AST_UNMAP: assert property (reg_rd && reg_addr == 16'hFF81 |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	AST_MODE_WR: assert property (reg_wr && reg_addr == `TWS_MODE_ADDR
		##2 reg_rd && reg_addr == `TWS_MODE_ADDR
		|=> {reg_rdata[7:6], reg_rdata[4]} == $past({reg_wdata[7:6], reg_wdata[4]}, 3))
		else $error("mode write lost");
	AST_BIT_WR: assert property (reg_bit_wr && !reg_wr && reg_addr == `TWS_MODE_ADDR
		&& reg_bit_idx[2] ##2 reg_rd && reg_addr == `TWS_MODE_ADDR
		|=> reg_rdata[$past(reg_bit_idx, 3)] == $past(reg_bit_val, 3))
		else $error("bit write lost");
	AST_TXB_RD: assert property (reg_wr && reg_addr == `TWS_TXB_ADDR
		##2 reg_rd && reg_addr == `TWS_TXB_ADDR
		|=> reg_rdata == $past(reg_wdata, 3))
		else $error("tx buffer lost");
	AST_SO_HOLD: assert property ($rose(serial_clock_line) |-> $stable(serial_out_line) [*3])
		else $error("out line moved at clock rise");
	AST_SO_FALL: assert property ($fell(serial_clock_line) |-> $stable(serial_out_line) [*5])
		else $error("out line moved in low phase");
	cover property ($rose(serial_clock_line));
	cover property (reg_wr && reg_addr == `TWS_TXB_ADDR);
	cover property (reg_rd && reg_addr == `TWS_SIO_ADDR);
endmodule
bind tws_port tws_port_props u_props (.mclk, .rst_b, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
	.reg_bit_wr, .reg_bit_idx, .reg_bit_val, .reg_rdata, .serial_clock_line, .serial_out_line);

// File: hdl/tws_port.sv
// Three-wire serial port channel: CPU registers, transfer control and link-side shifter
`timescale 1ns/10ps
`include "tws_params.svh"

module tws_port #(
	parameter bit HAS_SLAVE_SELECT = 1'b1
) (
	// System clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// CPU register port
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_bit_wr,
	input wire logic [2:0] reg_bit_idx,
	input wire logic reg_bit_val,
	output logic [7:0] reg_rdata,
	// Serial link
	input wire logic serial_clock_line,
	input wire logic serial_in_line,
	input wire logic slave_select_input_b,
	output logic serial_out_line
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	tws_pkg::tws_state_e state_q, state_d;
	tws_pkg::tws_byte_t mode_q, mode_d;
	tws_pkg::tws_byte_t txb_q, txb_d;
	tws_pkg::tws_byte_t sio_q, sio_d;
	tws_pkg::tws_byte_t rdata_q, rdata_d;
	logic arm_q, arm_d;
	logic so_q, so_d;
	logic link_rst_b;
	tws_pkg::tws_cnt_t lcnt_q, lcnt_d;
	tws_pkg::tws_byte_t lrx_q, lrx_d;
	tws_pkg::tws_cnt_t cnt_sync;
	logic ssel_sync;
	logic sel_mode, sel_txb, sel_sio;
	logic enabled, duplex, lsb_first, use_ssel, ssel_ok;
	logic start_tx, start_rx;
	logic [3:0] done_bin;
	logic [2:0] bit_idx;
	tws_pkg::tws_byte_t rx_ordered;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [3:0] gray_to_bin(input logic [3:0] g);
		logic [3:0] b;
		b[3] = g[3];
		b[2] = b[3] ^ g[2];
		b[1] = b[2] ^ g[1];
		b[0] = b[1] ^ g[0];
		return b;
	endfunction

	function automatic logic [3:0] bin_to_gray(input logic [3:0] b);
		return b ^ {1'b0, b[3:1]};
	endfunction

	function automatic tws_pkg::tws_byte_t bit_reverse(input tws_pkg::tws_byte_t v);
		tws_pkg::tws_byte_t r;
		for (int i = 0; i < 8; i++) begin
			r[i] = v[7-i];
		end
		return r;
	endfunction

	// ------------------------------------------------------------
	// Crossings into the system clock
	// ------------------------------------------------------------
	tws_sync #(
		.WIDTH(4),
		.INIT(`TWS_GRAY_ZERO)
	) u_cnt_sync (
		.clk(mclk),
		.rst_b(rst_b),
		.din(lcnt_q),
		.dout(cnt_sync)
	);

	tws_sync #(
		.WIDTH(1),
		.INIT(1'b1)
	) u_ssel_sync (
		.clk(mclk),
		.rst_b(rst_b),
		.din(slave_select_input_b),
		.dout(ssel_sync)
	);

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	always_comb begin
		sel_mode = 1'b0;
		sel_txb = 1'b0;
		sel_sio = 1'b0;
		if (reg_addr == `TWS_MODE_ADDR) begin
			sel_mode = 1'b1;
		end else if (reg_addr == `TWS_TXB_ADDR) begin
			sel_txb = 1'b1;
		end else if (reg_addr == `TWS_SIO_ADDR) begin
			sel_sio = 1'b1;
		end
	end

	assign enabled = mode_q[`TWS_EN_BIT];
	assign duplex = mode_q[`TWS_TRMD_BIT];
	assign lsb_first = mode_q[`TWS_DIR_BIT];
	assign use_ssel = HAS_SLAVE_SELECT & mode_q[`TWS_SSE_BIT];
	assign ssel_ok = !use_ssel || !ssel_sync;
	assign start_tx = sel_txb && reg_wr && enabled && duplex && ssel_ok && (state_q == tws_pkg::TWS_IDLE);
	assign start_rx = sel_sio && reg_rd && enabled && !duplex && ssel_ok && (state_q == tws_pkg::TWS_IDLE);
	assign done_bin = gray_to_bin(cnt_sync);
	assign rx_ordered = lsb_first ? bit_reverse(lrx_q) : lrx_q;

	// ------------------------------------------------------------
	// Register file and transfer control
	// ------------------------------------------------------------
	always_comb begin
		mode_d = mode_q;
		txb_d = txb_q;
		sio_d = sio_q;
		state_d = state_q;
		arm_d = arm_q;
		rdata_d = rdata_q;
		if (sel_mode && reg_wr) begin
			mode_d = reg_wdata & `TWS_MODE_WMASK;
		end else if (sel_mode && reg_bit_wr) begin
			mode_d[reg_bit_idx] = reg_bit_val;
			mode_d = mode_d & `TWS_MODE_WMASK;
		end
		if (!HAS_SLAVE_SELECT) begin
			mode_d[`TWS_SSE_BIT] = 1'b0;
		end
		if (sel_txb && reg_wr) begin
			txb_d = reg_wdata;
		end
		if (reg_rd) begin
			if (sel_mode) begin
				rdata_d = mode_q;
				rdata_d[`TWS_ACT_BIT] = (state_q != tws_pkg::TWS_IDLE);
			end else if (sel_txb) begin
				rdata_d = txb_q;
			end else if (sel_sio) begin
				rdata_d = sio_q;
			end else begin
				rdata_d = `TWS_BYTE_RST;
			end
		end
		case (state_q)
			tws_pkg::TWS_IDLE: begin
				if (start_tx || start_rx) begin
					arm_d = 1'b1;
					state_d = tws_pkg::TWS_RUN;
				end
			end
			tws_pkg::TWS_RUN: begin
				if (done_bin == `TWS_FRAME_BITS) begin
					sio_d = rx_ordered;
					arm_d = 1'b0;
					state_d = tws_pkg::TWS_DRAIN;
				end
			end
			tws_pkg::TWS_DRAIN: begin
				if (cnt_sync == `TWS_GRAY_ZERO) begin
					state_d = tws_pkg::TWS_IDLE;
				end
			end
			default: begin
				state_d = tws_pkg::TWS_IDLE;
			end
		endcase
		if (!mode_d[`TWS_EN_BIT]) begin
			arm_d = 1'b0;
			sio_d = `TWS_BYTE_RST;
			state_d = tws_pkg::TWS_IDLE;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			mode_q <= `TWS_MODE_RST;
			txb_q <= `TWS_BYTE_RST;
			sio_q <= `TWS_BYTE_RST;
			rdata_q <= `TWS_BYTE_RST;
			state_q <= tws_pkg::TWS_IDLE;
			arm_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			txb_q <= txb_d;
			sio_q <= sio_d;
			rdata_q <= rdata_d;
			state_q <= state_d;
			arm_q <= arm_d;
		end
	end

	// ------------------------------------------------------------
	// Serial output
	// ------------------------------------------------------------
	always_comb begin
		bit_idx = (done_bin[3] || state_q != tws_pkg::TWS_RUN) ? 3'h0 : done_bin[2:0];
		if (!lsb_first) begin
			bit_idx = `TWS_LAST_IDX - bit_idx;
		end
		so_d = 1'b0;
		if (duplex && enabled) begin
			so_d = txb_q[bit_idx];
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			so_q <= 1'b0;
		end else begin
			so_q <= so_d;
		end
	end

	// ------------------------------------------------------------
	// Link-side shifter on the serial clock
	// ------------------------------------------------------------
	assign link_rst_b = rst_b & arm_q;

	always_comb begin
		lcnt_d = lcnt_q;
		lrx_d = lrx_q;
		if (gray_to_bin(lcnt_q) != `TWS_FRAME_BITS) begin
			lrx_d = {lrx_q[6:0], serial_in_line};
			lcnt_d = bin_to_gray(gray_to_bin(lcnt_q) + 4'h1);
		end
	end

	always_ff @(posedge serial_clock_line or negedge link_rst_b) begin
		if (!link_rst_b) begin
			lcnt_q <= `TWS_GRAY_ZERO;
			lrx_q <= `TWS_BYTE_RST;
		end else begin
			lcnt_q <= lcnt_d;
			lrx_q <= lrx_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign reg_rdata = rdata_q;
	assign serial_out_line = so_q;

endmodule

// File: hdl/tws_sync.sv
// Three-stage synchroniser that accepts a value once stages two and three agree
`timescale 1ns/10ps
module tws_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Data
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q;
	logic [WIDTH-1:0] out_d;

	always_comb begin
		out_d = out_q;
		if (s2_q == s3_q) begin
			out_d = s3_q;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_q <= INIT;
			s2_q <= INIT;
			s3_q <= INIT;
			out_q <= INIT;
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
			out_q <= out_d;
		end
	end

	assign dout = out_q;

endmodule

// File: pkg/tws_params.svh
// Register map, field positions, reset values and counts of the three-wire serial port
`ifndef TWS_PARAMS_SVH
`define TWS_PARAMS_SVH

`define TWS_MODE_ADDR 16'hFF80
`define TWS_TXB_ADDR 16'hFF84
`define TWS_SIO_ADDR 16'hFF85
`define TWS_EN_BIT 7
`define TWS_TRMD_BIT 6
`define TWS_SSE_BIT 5
`define TWS_DIR_BIT 4
`define TWS_ACT_BIT 0
`define TWS_MODE_WMASK 8'hF0
`define TWS_MODE_RST 8'h00
`define TWS_BYTE_RST 8'h00
`define TWS_FRAME_BITS 4'h8
`define TWS_GRAY_ZERO 4'h0
`define TWS_LAST_IDX 3'h7

`endif

// File: pkg/tws_pkg.sv
// Types shared by the three-wire serial port
package tws_pkg;

	typedef logic [7:0] tws_byte_t;
	typedef logic [3:0] tws_cnt_t;

	typedef enum logic [1:0] {
		TWS_IDLE,
		TWS_RUN,
		TWS_DRAIN
	} tws_state_e;

endpackage
